/* include/htcfg_pkg.sv */
// htcfg_pkg: constants for the hypervisor trap configuration registers.
// assumes a single core clock domain and a system-coprocessor move port.
`default_nettype none
package htcfg_pkg;
   // ======================================================================
   // move encoding of the two registers
   localparam logic [2:0] OPC1_HYP = 3'h4;
   localparam logic [3:0] CRN_HYP = 4'h1;
   localparam logic [3:0] CRM_HYP = 4'h1;
   localparam logic [2:0] OPC2_DBG = 3'h1;
   localparam logic [2:0] OPC2_CPT = 3'h2;
   // ======================================================================
   // debug configuration register fields
   localparam int DBG_ROM_BIT = 11;
   localparam int DBG_OS_BIT = 10;
   localparam int DBG_ACC_BIT = 9;
   localparam int DBG_EXC_BIT = 8;
   localparam int HPME_BIT = 7;
   localparam int PM_BIT = 6;
   localparam int PMCR_BIT = 5;
   localparam int LIMIT_MSB = 4;
   localparam int LIMIT_W = 5;
   localparam logic [31:0] DBG_WR_MASK = 32'h0000_0FFF;
   localparam logic HPME_RST = 1'h0;
   localparam int DEF_COUNTERS = 6;
   // ======================================================================
   // coprocessor trap register fields
   localparam int CPAC_BIT = 31;
   localparam int SIMD_BIT = 15;
   localparam int CP11_BIT = 11;
   localparam int CP10_BIT = 10;
   localparam logic [31:0] CPT_WR_MASK = 32'h8000_8C00;
   localparam logic [31:0] CPT_ONES = 32'h0000_33FF;
   localparam logic [31:0] CPT_RST = 32'h0000_0000;
endpackage : htcfg_pkg
`default_nettype wire

/* core/htcfg_trap_eval.sv */
// htcfg_trap_eval: combinational trap decision for one classified access.
// assumes the caller registers the results and supplies effective values.
`timescale 1ns/100ps
`default_nettype none
module htcfg_trap_eval
   import htcfg_pkg::*;
(
   input wire logic [31:0] dbgCfg,
   input wire logic [31:0] cptEff,
   input wire logic hypMode,
   input wire logic nonSecureState,
   input wire logic qDebugRom,
   input wire logic qOsDebug,
   input wire logic qDebugOther,
   input wire logic qDebugExc,
   input wire logic qPerfmon,
   input wire logic qPerfControl,
   input wire logic qAccessControl,
   input wire logic qSimd,
   input wire logic qCp10,
   input wire logic qCp11,
   input wire logic qCounter,
   input wire logic [LIMIT_W-1:0] qCounterIdx,
   output logic trapToHyp,
   output logic undefInHyp,
   output logic counterDenied
);
   // ======================================================================
   // guest context: non-secure PL1 or PL0
   wire logic guest;
   wire logic simdBlocked;
   wire logic cp10Blocked;
   wire logic cp11Blocked;
   wire logic debugTrap;
   wire logic perfTrap;
   wire logic cpTrap;
   assign guest = nonSecureState & ~hypMode;
   // both fp coprocessor bits set block all simd use
   assign simdBlocked = qSimd & (cptEff[SIMD_BIT]
      | (cptEff[CP10_BIT] & cptEff[CP11_BIT]));
   assign cp10Blocked = qCp10 & cptEff[CP10_BIT];
   assign cp11Blocked = qCp11 & cptEff[CP11_BIT];
   // debug register classes are disjoint, each has its own bit
   assign debugTrap = (qDebugRom & dbgCfg[DBG_ROM_BIT])
      | (qOsDebug & dbgCfg[DBG_OS_BIT])
      | (qDebugOther & dbgCfg[DBG_ACC_BIT]);
   assign perfTrap = (qPerfmon & dbgCfg[PM_BIT])
      | (qPerfControl & dbgCfg[PMCR_BIT]);
   // guest access-control accesses trap; hyp never consults that register
   assign cpTrap = (qAccessControl & cptEff[CPAC_BIT])
      | simdBlocked | cp10Blocked | cp11Blocked;
   // ======================================================================
   // final decisions
   assign trapToHyp = (guest & (debugTrap | perfTrap | cpTrap))
      | (qDebugExc & nonSecureState & dbgCfg[DBG_EXC_BIT]);
   assign undefInHyp = hypMode
      & (simdBlocked | cp10Blocked | cp11Blocked);
   // counters at or above the guest limit belong to PL2 only
   assign counterDenied = guest & qCounter
      & (qCounterIdx >= dbgCfg[LIMIT_MSB:0]);
endmodule : htcfg_trap_eval
`default_nettype wire

/* core/htcfg_trap_regs.sv */
// htcfg_trap_regs: hypervisor debug configuration and coprocessor trap
// registers with their trap decisions and hyp counter enables.
// assumes inputs synchronous to sys_clk and one move request per pulse.
`timescale 1ns/100ps
`default_nettype none
module htcfg_trap_regs
   import htcfg_pkg::*;
#(
   parameter int NUM_COUNTERS = DEF_COUNTERS,
   parameter bit HAS_FP = 1'b1,
   parameter bit HAS_SIMD = 1'b1
)
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic cpReq,
   input wire logic cpWrite,
   input wire logic [2:0] cpOpc1,
   input wire logic [3:0] cpCrn,
   input wire logic [3:0] cpCrm,
   input wire logic [2:0] cpOpc2,
   input wire logic [31:0] cpWrData,
   input wire logic hypMode,
   input wire logic monitorMode,
   input wire logic securityStateSelector,
   input wire logic nonSecureState,
   input wire logic nsCp10Allow,
   input wire logic nsCp11Allow,
   input wire logic nonsecureSimdDisable,
   input wire logic qValid,
   input wire logic qDebugRom,
   input wire logic qOsDebug,
   input wire logic qDebugOther,
   input wire logic qDebugExc,
   input wire logic qPerfmon,
   input wire logic qPerfControl,
   input wire logic qAccessControl,
   input wire logic qSimd,
   input wire logic qCp10,
   input wire logic qCp11,
   input wire logic qCounter,
   input wire logic [LIMIT_W-1:0] qCounterIdx,
   output logic cpAck_r,
   output logic cpUndef_r,
   output logic [31:0] cpRdData_r,
   output logic qDone_r,
   output logic trapToHyp_r,
   output logic undefInHyp_r,
   output logic counterDenied_r,
   output logic [NUM_COUNTERS-1:0] counterEnable_r
);
   // ======================================================================
   // elaboration check
   generate
      if (NUM_COUNTERS < 1 || NUM_COUNTERS > 31)
      begin : g_badCount
         $error("counter count must lie between 1 and 31");
      end
   endgenerate

   localparam logic [LIMIT_W-1:0] LIMIT_RST = LIMIT_W'(NUM_COUNTERS);
   localparam logic NO_FP_UNIT = ~HAS_FP & ~HAS_SIMD;

   // ======================================================================
   // move decode and privilege
   wire logic encHit;
   wire logic hitDbg;
   wire logic hitCpt;
   wire logic privOk;
   wire logic takeDbg;
   wire logic takeCpt;
   wire logic refuse;
   // only encoding opcode1 4, c1, c1 with opcode2 1 or 2 belongs here
   assign encHit = cpReq & (cpOpc1 == OPC1_HYP) & (cpCrn == CRN_HYP)
      & (cpCrm == CRM_HYP);
   assign hitDbg = encHit & (cpOpc2 == OPC2_DBG);
   assign hitCpt = encHit & (cpOpc2 == OPC2_CPT);
   // hyp mode, or monitor with the non-secure selector set
   assign privOk = hypMode | (monitorMode & securityStateSelector);
   assign takeDbg = hitDbg & privOk;
   assign takeCpt = hitCpt & privOk;
   assign refuse = (hitDbg | hitCpt) & ~privOk;

   // ======================================================================
   // debug configuration register
   logic [31:0] dbgCfg_r;
   wire logic [31:0] dbgCfg_nxt;
   // upper field stays zero, every write is masked to the live bits
   assign dbgCfg_nxt = (takeDbg & cpWrite) ? (cpWrData & DBG_WR_MASK)
      : dbgCfg_r;

   // hyp counter enable has no meaningful reset, give it a defined one
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         dbgCfg_r <= '0;
         dbgCfg_r[HPME_BIT] <= HPME_RST;
         dbgCfg_r[LIMIT_MSB:0] <= LIMIT_RST;
      end
      else
      begin
         dbgCfg_r <= dbgCfg_nxt;
      end
   end

   // ======================================================================
   // coprocessor trap register
   logic [31:0] cptStore_r;
   wire logic [31:0] forceOnes;
   wire logic [31:0] cptWen;
   wire logic [31:0] cptEff;
   wire logic [31:0] cptStore_nxt;
   // bits pinned at one by missing units or by nonsecure access control
   assign forceOnes[SIMD_BIT] = ~HAS_SIMD | NO_FP_UNIT
      | nonsecureSimdDisable;
   assign forceOnes[CP11_BIT] = NO_FP_UNIT | ~nsCp11Allow;
   assign forceOnes[CP10_BIT] = NO_FP_UNIT | ~nsCp10Allow;
   assign forceOnes[31:16] = '0;
   assign forceOnes[14:12] = '0;
   assign forceOnes[9:0] = '0;
   // pinned and reserved bits ignore writes
   assign cptWen = (takeCpt & cpWrite) ? (CPT_WR_MASK & ~forceOnes)
      : '0;
   assign cptStore_nxt = (cptStore_r & ~cptWen) | (cpWrData & cptWen);
   // access control takes precedence over the stored trap bits
   assign cptEff = cptStore_r | forceOnes | CPT_ONES;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         cptStore_r <= CPT_RST;
      else
         cptStore_r <= cptStore_nxt;
   end

   // ======================================================================
   // move response: one cycle after the request
   wire logic [31:0] rdSel;
   assign rdSel = hitDbg ? dbgCfg_r : cptEff;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         cpAck_r <= 1'b0;
         cpUndef_r <= 1'b0;
         cpRdData_r <= '0;
      end
      else
      begin
         cpAck_r <= takeDbg | takeCpt;
         cpUndef_r <= refuse;
         cpRdData_r <= ((takeDbg | takeCpt) & ~cpWrite) ? rdSel : '0;
      end
   end

   // ======================================================================
   // trap decision for classified accesses
   wire logic trapNow;
   wire logic undefNow;
   wire logic deniedNow;

   htcfg_trap_eval u_eval (
      .dbgCfg(dbgCfg_r),
      .cptEff(cptEff),
      .hypMode(hypMode),
      .nonSecureState(nonSecureState),
      .qDebugRom(qDebugRom),
      .qOsDebug(qOsDebug),
      .qDebugOther(qDebugOther),
      .qDebugExc(qDebugExc),
      .qPerfmon(qPerfmon),
      .qPerfControl(qPerfControl),
      .qAccessControl(qAccessControl),
      .qSimd(qSimd),
      .qCp10(qCp10),
      .qCp11(qCp11),
      .qCounter(qCounter),
      .qCounterIdx(qCounterIdx),
      .trapToHyp(trapNow),
      .undefInHyp(undefNow),
      .counterDenied(deniedNow)
   );

   // results stand for one cycle, gated by the query strobe
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         qDone_r <= 1'b0;
         trapToHyp_r <= 1'b0;
         undefInHyp_r <= 1'b0;
         counterDenied_r <= 1'b0;
      end
      else
      begin
         qDone_r <= qValid;
         trapToHyp_r <= qValid & trapNow;
         undefInHyp_r <= qValid & undefNow;
         counterDenied_r <= qValid & deniedNow;
      end
   end

   // ======================================================================
   // per counter enable: guest range open, hyp range follows enable bit
   genvar ci;
   generate
      for (ci = 0; ci < NUM_COUNTERS; ci++)
      begin : g_cnt
         wire logic hypRange;
         assign hypRange = LIMIT_W'(ci) >= dbgCfg_r[LIMIT_MSB:0];
         always_ff @(posedge sys_clk)
         begin
            if (srst)
               counterEnable_r[ci] <= 1'b1;
            else
               counterEnable_r[ci] <= ~hypRange | dbgCfg_r[HPME_BIT];
         end
      end
   endgenerate

   // ======================================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_query(logic cls);
      qValid & cls & nonSecureState & ~hypMode;
   endsequence

   sequence s_hypQuery(logic cls);
      qValid & cls & hypMode;
   endsequence

   AST_PRIV_REFUSE: assert property (
      (hitDbg | hitCpt) & ~privOk |=> cpUndef_r & ~cpAck_r)
      else $error("unprivileged move not refused");

   AST_OS_TRAP: assert property (
      s_query(qOsDebug & dbgCfg_r[DBG_OS_BIT]) |=> trapToHyp_r & qDone_r)
      else $error("os debug access not trapped");

   AST_DBG_NO_TRAP: assert property (
      s_query(qDebugOther & ~dbgCfg_r[DBG_ACC_BIT] & ~qOsDebug & ~qDebugRom
      & ~qDebugExc & ~qPerfmon & ~qPerfControl & ~qAccessControl & ~qSimd
      & ~qCp10 & ~qCp11) |=> ~trapToHyp_r)
      else $error("debug access trapped with bit clear");

   AST_ROM_TRAP: assert property (
      s_query(qDebugRom & dbgCfg_r[DBG_ROM_BIT]) |=> trapToHyp_r)
      else $error("debug rom access not trapped");

   AST_EXC_ROUTE: assert property (
      qValid & qDebugExc & nonSecureState & dbgCfg_r[DBG_EXC_BIT]
      |=> trapToHyp_r)
      else $error("debug exception not routed to hyp");

   AST_PERF_TRAP: assert property (
      s_query(qPerfmon & dbgCfg_r[PM_BIT] | qPerfControl & dbgCfg_r[PMCR_BIT])
      |=> trapToHyp_r)
      else $error("performance access not trapped");

   AST_HYP_ENABLE: assert property (
      dbgCfg_r[LIMIT_MSB:0] <= LIMIT_W'(NUM_COUNTERS - 1)
      |=> counterEnable_r[NUM_COUNTERS-1] == $past(dbgCfg_r[HPME_BIT]))
      else $error("hyp counter enable does not follow its bit");

   AST_LIMIT_RESET: assert property (
      disable iff (1'b0) $past(srst) |-> dbgCfg_r[LIMIT_MSB:0] == LIMIT_RST
      && dbgCfg_r[DBG_ROM_BIT:PMCR_BIT] == '0)
      else $error("guest counter limit not reset");

   AST_CPAC_TRAP: assert property (
      s_query(qAccessControl & cptEff[CPAC_BIT]) |=> trapToHyp_r)
      else $error("access control access not trapped");

   AST_HYP_SIMD_UNDEF: assert property (
      s_hypQuery(qSimd & ~qDebugExc & cptEff[CP10_BIT] & cptEff[CP11_BIT])
      |=> undefInHyp_r & ~trapToHyp_r)
      else $error("hyp simd use not undefined");

   AST_PINNED_ONES: assert property (
      (~nonsecureSimdDisable | cptEff[SIMD_BIT]) & (nsCp10Allow | cptEff[CP10_BIT])
      & (nsCp11Allow | cptEff[CP11_BIT]))
      else $error("pinned trap bit not read as one");

   AST_PINNED_KEEP: assert property (
      takeCpt & cpWrite & ~nsCp10Allow
      |=> cptStore_r[CP10_BIT] == $past(cptStore_r[CP10_BIT]))
      else $error("pinned trap bit took a write");

   AST_RESERVED: assert property (
      dbgCfg_r[31:LIMIT_W+7] == '0 && (cptEff & CPT_ONES) == CPT_ONES
      && cptEff[30:16] == '0 && ~cptEff[14])
      else $error("reserved field holds wrong value");

   AST_CP_TRAP: assert property (
      s_query(qCp10 & cptEff[CP10_BIT] | qCp11 & cptEff[CP11_BIT])
      |=> trapToHyp_r ##1 ~trapToHyp_r | qDone_r)
      else $error("guest fp coprocessor access not trapped");

   AST_COUNTER_DENY: assert property (
      s_query(qCounter & (qCounterIdx >= dbgCfg_r[LIMIT_MSB:0]))
      |=> counterDenied_r)
      else $error("guest reached a hyp counter");
endmodule : htcfg_trap_regs
`default_nettype wire

/* bench/tb_hyp_trap_config_regs.sv */
// tb_hyp_trap_config_regs: self-checking bench for the hyp trap registers.
// assumes htcfg_pkg is compiled first and the design keeps its defaults.
`timescale 1ns/100ps
`default_nettype none
module tb_hyp_trap_config_regs
   import htcfg_pkg::*;
   ;
   // ======================================================================
   // stimulus tables: mode context is {hyp, monitor, selector, nonsecure}
   localparam logic [3:0] HYP = 4'hB;
   localparam logic [3:0] GUEST = 4'h1;
   localparam logic [31:0] DBG_SEL [5] = '{32'h800, 32'h400, 32'h200, 32'h40, 32'h20};
   localparam logic [10:0] DBG_Q [5] = '{11'h001, 11'h002, 11'h004, 11'h010, 11'h020};
   localparam logic [31:0] CPT_SEL [4] = '{32'h8000_0000, 32'h400, 32'h800, 32'h8000};
   localparam logic [10:0] CPT_Q [4] = '{11'h040, 11'h100, 11'h200, 11'h080};
   localparam logic [2:0] DIS [3] = '{3'h2, 3'h1, 3'h7};
   localparam logic [31:0] PIN [3] = '{32'h400, 32'h800, 32'h8000};
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic cpReq = 1'b0;
   logic cpWrite = 1'b0;
   logic [2:0] cpOpc1 = OPC1_HYP;
   logic [3:0] cpCrn = CRN_HYP;
   logic [3:0] cpCrm = CRM_HYP;
   logic [2:0] cpOpc2 = 3'h0;
   logic [31:0] cpWrData = 32'h0;
   logic hypMode = 1'b0;
   logic monitorMode = 1'b0;
   logic securityStateSelector = 1'b0;
   logic nonSecureState = 1'b0;
   logic nsCp10Allow = 1'b1;
   logic nsCp11Allow = 1'b1;
   logic nonsecureSimdDisable = 1'b0;
   logic qValid = 1'b0;
   logic [10:0] qCls = 11'h0;
   logic [4:0] qIdx = 5'h0;
   logic cpAck_r, cpUndef_r, qDone_r, trapToHyp_r, undefInHyp_r, counterDenied_r;
   logic [31:0] cpRdData_r;
   logic [DEF_COUNTERS-1:0] counterEnable_r;
   int fails = 0;
   int checks = 0;
   int cycles = 0;

   // clock, 20 ns period
   always #10 sys_clk = ~sys_clk;

   htcfg_trap_regs uut
   (
      .sys_clk(sys_clk), .srst(srst), .cpReq(cpReq), .cpWrite(cpWrite),
      .cpOpc1(cpOpc1), .cpCrn(cpCrn), .cpCrm(cpCrm), .cpOpc2(cpOpc2),
      .cpWrData(cpWrData), .hypMode(hypMode), .monitorMode(monitorMode),
      .securityStateSelector(securityStateSelector), .nonSecureState(nonSecureState),
      .nsCp10Allow(nsCp10Allow), .nsCp11Allow(nsCp11Allow),
      .nonsecureSimdDisable(nonsecureSimdDisable), .qValid(qValid),
      .qDebugRom(qCls[0]), .qOsDebug(qCls[1]), .qDebugOther(qCls[2]),
      .qDebugExc(qCls[3]), .qPerfmon(qCls[4]), .qPerfControl(qCls[5]),
      .qAccessControl(qCls[6]), .qSimd(qCls[7]), .qCp10(qCls[8]), .qCp11(qCls[9]),
      .qCounter(qCls[10]), .qCounterIdx(qIdx), .cpAck_r(cpAck_r),
      .cpUndef_r(cpUndef_r), .cpRdData_r(cpRdData_r), .qDone_r(qDone_r),
      .trapToHyp_r(trapToHyp_r), .undefInHyp_r(undefInHyp_r),
      .counterDenied_r(counterDenied_r), .counterEnable_r(counterEnable_r)
   );

   // ======================================================================
   // shared tasks
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   // compare one seen value against its expectation
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one move; expAns is {ack, undef}
   task automatic cpMove(input logic w, input logic [2:0] op2, input logic [31:0] d,
                         input logic [1:0] expAns, input logic [31:0] expRd);
      @(posedge sys_clk);
      cpReq <= 1'b1;
      cpWrite <= w;
      cpOpc2 <= op2;
      cpWrData <= d;
      @(posedge sys_clk);
      cpReq <= 1'b0;
      #1;
      check({30'h0, cpAck_r, cpUndef_r}, {30'h0, expAns});
      check(cpRdData_r, expRd);
   endtask : cpMove

   task automatic wr(input logic [2:0] op2, input logic [31:0] d);
      cpMove(1'b1, op2, d, 2'b10, 32'h0);
   endtask : wr

   task automatic rd(input logic [2:0] op2, input logic [31:0] e);
      cpMove(1'b0, op2, 32'h0, 2'b10, e);
   endtask : rd

   task automatic ctx(input logic [3:0] c);
      @(posedge sys_clk);
      {hypMode, monitorMode, securityStateSelector, nonSecureState} <= c;
   endtask : ctx

   // one trap query; exp is {trap, undef, denied}
   task automatic query(input logic [10:0] cls, input logic [4:0] idx,
                        input logic [2:0] exp);
      @(posedge sys_clk);
      qValid <= 1'b1;
      qCls <= cls;
      qIdx <= idx;
      @(posedge sys_clk);
      qValid <= 1'b0;
      qCls <= 11'h0;
      #1;
      check({28'h0, qDone_r, trapToHyp_r, undefInHyp_r, counterDenied_r},
            {28'h0, 1'b1, exp});
   endtask : query

   // hang guard: well above the few hundred cycles the tests need
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fails++;
         end_of_test();
      end
   end

   // ======================================================================
   // main sequence
   initial
   begin
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      ctx(HYP);
      rd(OPC2_DBG, 32'h0000_0006);
      rd(OPC2_CPT, CPT_ONES);
      check({26'h0, counterEnable_r}, {26'h0, 6'h3F});
      $display("test reset values done");
      ctx(GUEST);
      cpMove(1'b0, OPC2_DBG, 32'h0, 2'b01, 32'h0);
      ctx(4'h4);
      cpMove(1'b1, OPC2_DBG, 32'hFFF, 2'b01, 32'h0);
      ctx(4'h6);
      rd(OPC2_DBG, 32'h0000_0006);
      cpMove(1'b1, 3'h3, 32'hFFF, 2'b00, 32'h0);
      @(posedge sys_clk);
      cpCrm <= 4'h0;
      cpMove(1'b1, OPC2_DBG, 32'hFFF, 2'b00, 32'h0);
      @(posedge sys_clk);
      cpCrm <= CRM_HYP;
      rd(OPC2_DBG, 32'h0000_0006);
      wr(OPC2_DBG, 32'hFFFF_FFFF);
      rd(OPC2_DBG, 32'h0000_0FFF);
      $display("test privilege and encoding done");
      ctx(HYP);
      wr(OPC2_DBG, 32'h0000_0003);
      @(posedge sys_clk);
      #1;
      check({26'h0, counterEnable_r}, {26'h0, 6'h07});
      ctx(GUEST);
      query(11'h400, 5'h2, 3'b000);
      query(11'h400, 5'h3, 3'b001);
      ctx(HYP);
      query(11'h400, 5'h5, 3'b000);
      wr(OPC2_DBG, 32'h0000_0083);
      @(posedge sys_clk);
      #1;
      check({26'h0, counterEnable_r}, {26'h0, 6'h3F});
      $display("test counter partition done");
      for (int i = 0; i < 5; i++)
      begin
         ctx(HYP);
         wr(OPC2_DBG, 32'h6 | DBG_SEL[i]);
         ctx(GUEST);
         for (int j = 0; j < 5; j++)
            query(DBG_Q[j], 5'h0, {(i == j), 2'b00});
      end
      ctx(HYP);
      wr(OPC2_DBG, 32'h0000_0F06);
      query(11'h008, 5'h0, 3'b100);
      ctx(4'h0);
      query(11'h008, 5'h0, 3'b000);
      ctx(HYP);
      wr(OPC2_DBG, 32'h0000_0E06);
      ctx(GUEST);
      query(11'h008, 5'h0, 3'b000);
      $display("test debug traps done");
      for (int i = 0; i < 4; i++)
      begin
         ctx(HYP);
         wr(OPC2_CPT, CPT_SEL[i]);
         rd(OPC2_CPT, CPT_ONES | CPT_SEL[i]);
         for (int j = 0; j < 4; j++)
            query(CPT_Q[j], 5'h0, {1'b0, (i == j) && (j != 0), 1'b0});
         ctx(GUEST);
         for (int j = 0; j < 4; j++)
            query(CPT_Q[j], 5'h0, {(i == j), 2'b00});
      end
      ctx(HYP);
      wr(OPC2_CPT, 32'h0000_0C00);
      query(11'h080, 5'h0, 3'b010);
      ctx(GUEST);
      query(11'h080, 5'h0, 3'b100);
      for (int k = 0; k < 3; k++)
      begin
         ctx(HYP);
         @(posedge sys_clk);
         {nonsecureSimdDisable, nsCp11Allow, nsCp10Allow} <= DIS[k];
         wr(OPC2_CPT, 32'h0);
         rd(OPC2_CPT, CPT_ONES | PIN[k]);
         ctx(GUEST);
         query(CPT_Q[(k == 2) ? 3 : k + 1], 5'h0, 3'b100);
      end
      @(posedge sys_clk);
      {nonsecureSimdDisable, nsCp11Allow, nsCp10Allow} <= 3'h3;
      $display("test coprocessor traps done");
      ctx(HYP);
      @(posedge sys_clk);
      cpReq <= 1'b1;
      cpWrite <= 1'b1;
      cpOpc2 <= OPC2_DBG;
      cpWrData <= 32'h0000_0024;
      @(posedge sys_clk);
      cpWrite <= 1'b0;
      @(posedge sys_clk);
      cpReq <= 1'b0;
      #1;
      check(cpRdData_r, 32'h0000_0024);
      check({31'h0, cpAck_r}, 32'h0000_0001);
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      rd(OPC2_DBG, 32'h0000_0006);
      $display("test back to back and second reset done");
      end_of_test();
   end
endmodule : tb_hyp_trap_config_regs
`default_nettype wire
